// >>> design/cms_pkg.sv
// Package for the cache maintenance sequencer: commands, bus cycle codes,
// translation buffer geometry, descriptor codes and memory type encodings.
// Assumes a single core clock and a synchronous active-high reset.
package cms_pkg;

  // Maintenance commands presented on cmd_op.
  typedef enum logic [1:0] {
    CMS_CMD_NONE                         = 2'h0,
    CMS_CMD_INVALIDATE_WITHOUT_WRITEBACK = 2'h1,
    CMS_CMD_WRITEBACK_THEN_INVALIDATE    = 2'h2
  } cms_cmd_t;

  // Special bus cycle codes presented on sbc_code.
  typedef enum logic [1:0] {
    CMS_SBC_NONE     = 2'h0,
    CMS_SBC_SYNC     = 2'h1,
    CMS_SBC_FLUSH    = 2'h2
  } cms_sbc_t;

  // Memory type encodings used by the remap check.
  localparam logic [2:0] CMS_MT_UNCACHEABLE       = 3'h0;
  localparam logic [2:0] CMS_MT_WRITE_THROUGH_TYPE = 3'h4;
  localparam logic [2:0] CMS_MT_WRITE_BACK_TYPE    = 3'h6;

  // Cache geometry: sets and ways of each internal level.
  localparam int CMS_L1_SETS   = 128;
  localparam int CMS_L2_SETS   = 1024;
  localparam int CMS_WAYS      = 4;
  localparam int CMS_IDX_W     = 10;
  localparam int CMS_WAY_W     = 2;
  localparam logic [CMS_IDX_W-1:0] CMS_L1_LAST = CMS_IDX_W'(CMS_L1_SETS - 1);
  localparam logic [CMS_IDX_W-1:0] CMS_L2_LAST = CMS_IDX_W'(CMS_L2_SETS - 1);
  localparam logic [CMS_WAY_W-1:0] CMS_WAY_LAST = CMS_WAY_W'(CMS_WAYS - 1);

  // Translation buffer geometry.
  localparam int CMS_ITLB_SMALL_ENTRIES = 32;
  localparam int CMS_ITLB_SMALL_WAYS    = 4;
  localparam int CMS_ITLB_LARGE_ENTRIES = 2;
  localparam int CMS_ITLB_LARGE_WAYS    = 2;
  localparam int CMS_DTLB_SMALL_ENTRIES = 64;
  localparam int CMS_DTLB_SMALL_WAYS    = 4;

  // Descriptor bytes of the identification result.
  localparam logic [7:0] CMS_DESC_ITLB_SMALL = 8'h01;
  localparam logic [7:0] CMS_DESC_ITLB_LARGE = 8'h02;
  localparam logic [7:0] CMS_DESC_DTLB_SMALL = 8'h03;
  // Arbitrary low byte of the identification result.
  localparam logic [7:0] CMS_DESC_BYTE0      = 8'h01;

endpackage : cms_pkg

// >>> design/cms_sequencer.sv
// Cache maintenance sequencer: walks both internal cache levels on an
// invalidate or write-back-and-invalidate command, then issues special bus
// cycles to external caches. Also reports translation buffer descriptors and
// checks memory type remapping.
// Assumes the cache arrays sit outside and accept one line operation per
// accepted handshake, and the system bus takes special cycles by handshake.
`timescale 1ns/10ps

module cms_sequencer
  import cms_pkg::*;
(
  // Clock and reset.
  input  wire logic                 ref_clk,
  input  wire logic                 rst,
  // Command port.
  input  wire logic                 cmd_valid,
  output logic                      cmd_ready,
  input  wire cms_cmd_t             cmd_op,
  output logic                      cmd_done,
  output logic                      mem_hold,
  // Cache line port: probe reads status, write-back and invalidate act on a line.
  output logic                      line_valid,
  input  wire logic                 line_ready,
  output logic                      line_level,
  output logic [CMS_IDX_W-1:0]      line_index,
  output logic [CMS_WAY_W-1:0]      line_way,
  output logic                      line_writeback,
  output logic                      line_invalidate,
  input  wire logic                 line_dirty,
  // Special bus cycle port.
  output logic                      sbc_valid,
  input  wire logic                 sbc_ready,
  output cms_sbc_t                  sbc_code,
  // Identification and translation buffer geometry.
  output logic [31:0]               id_result,
  output logic [6:0]                itlb_small_entries,
  output logic [2:0]                itlb_small_ways,
  output logic [1:0]                itlb_large_entries,
  output logic                      itlb_large_full_assoc,
  output logic [6:0]                dtlb_small_entries,
  output logic [2:0]                dtlb_small_ways,
  // Memory type remap check.
  input  wire logic                 remap_valid,
  input  wire logic [2:0]           remap_from,
  input  wire logic [2:0]           remap_to,
  output logic                      remap_ok,
  output logic                      remap_refused
);

  // Walk states. Probe, write-back and invalidate each hold their line request
  // until line_ready, and the two bus states hold theirs until sbc_ready.
  typedef enum logic [2:0] {
    CMS_IDLE,
    CMS_PROBE,
    CMS_WRITEBACK,
    CMS_INVALIDATE,
    CMS_SYNC,
    CMS_FLUSH,
    CMS_DONE
  } cms_state_t;

  cms_state_t             state_reg;
  cms_state_t             state_next;
  logic                   wb_mode_reg;
  logic                   level_reg;
  logic [CMS_IDX_W-1:0]   index_reg;
  logic [CMS_WAY_W-1:0]   way_reg;
  logic                   last_line;
  logic                   line_fire;
  logic                   walk_step;
  logic                   set_end;

  // Last set of the level being walked.
  function automatic logic [CMS_IDX_W-1:0] last_index(input logic level);
    last_index = level ? CMS_L2_LAST : CMS_L1_LAST;
  endfunction : last_index

  // True for the one remap that would lose dirty data: write-back to write-through.
  function automatic logic remap_forbidden(input logic [2:0] from_type, input logic [2:0] to_type);
    remap_forbidden = (from_type == CMS_MT_WRITE_BACK_TYPE) && (to_type == CMS_MT_WRITE_THROUGH_TYPE);
  endfunction : remap_forbidden

  assign set_end   = (way_reg == CMS_WAY_LAST) && (index_reg == last_index(level_reg));
  assign last_line = level_reg && set_end;
  assign line_fire = line_valid && line_ready;
  assign walk_step = (state_reg == CMS_INVALIDATE) && line_fire && !last_line;

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      CMS_IDLE:
      begin
        if (cmd_valid && (cmd_op == CMS_CMD_WRITEBACK_THEN_INVALIDATE))
          state_next = CMS_PROBE;
        else if (cmd_valid && (cmd_op == CMS_CMD_INVALIDATE_WITHOUT_WRITEBACK))
          state_next = CMS_INVALIDATE;
      end
      CMS_PROBE:
      begin
        // Dirty lines go out whatever write policy they were cached under.
        if (line_ready)
          state_next = line_dirty ? CMS_WRITEBACK : CMS_INVALIDATE;
      end
      CMS_WRITEBACK:
      begin
        if (line_ready)
          state_next = CMS_INVALIDATE;
      end
      CMS_INVALIDATE:
      begin
        if (line_ready && last_line)
          state_next = wb_mode_reg ? CMS_SYNC : CMS_FLUSH;
        else if (line_ready && wb_mode_reg)
          state_next = CMS_PROBE;
      end
      CMS_SYNC:
      begin
        if (sbc_ready)
          state_next = CMS_FLUSH;
      end
      CMS_FLUSH:
      begin
        if (sbc_ready)
          state_next = CMS_DONE;
      end
      CMS_DONE:
        state_next = CMS_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      state_reg <= CMS_IDLE;
    else
      state_reg <= state_next;
  end

  // The mode is latched at acceptance because cmd_op may change while the walk
  // runs; a request with no operation leaves the machine idle either way.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      wb_mode_reg <= 1'b0;
    else if (state_reg == CMS_IDLE && cmd_valid)
      wb_mode_reg <= (cmd_op == CMS_CMD_WRITEBACK_THEN_INVALIDATE);
  end

  // Walk order is level 1 then level 2, every set, every way. The counters only
  // move on an accepted invalidate, so a stalled line request keeps its address.
  always_ff @(posedge ref_clk)
  begin
    if (rst || state_reg == CMS_IDLE)
      way_reg <= '0;
    else if (walk_step)
      way_reg <= way_reg + 1'b1;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst || state_reg == CMS_IDLE)
      index_reg <= '0;
    else if (walk_step && set_end)
      index_reg <= '0;
    else if (walk_step && (way_reg == CMS_WAY_LAST))
      index_reg <= index_reg + 1'b1;
  end

  // Level 2 is entered once and left only through idle, so no set is walked twice.
  always_ff @(posedge ref_clk)
  begin
    if (rst || state_reg == CMS_IDLE)
      level_reg <= 1'b0;
    else if (walk_step && set_end)
      level_reg <= 1'b1;
  end

  // Handshake outputs decode straight from the state so they never lag it by a cycle.
  assign cmd_ready  = (state_reg == CMS_IDLE);
  assign cmd_done   = (state_reg == CMS_DONE);
  // Holding accesses across the whole walk keeps new fills out of lines already cleared.
  assign mem_hold   = (state_reg != CMS_IDLE) && (state_reg != CMS_DONE);
  assign line_level = level_reg;
  assign line_index = index_reg;
  assign line_way   = way_reg;
  assign sbc_valid  = (state_reg == CMS_SYNC) || (state_reg == CMS_FLUSH);

  // A probe is a line request with neither write-back nor invalidate set.
  always_comb
  begin
    line_valid      = 1'b0;
    line_writeback  = 1'b0;
    line_invalidate = 1'b0;
    if (state_reg == CMS_PROBE)
      line_valid = 1'b1;
    else if (state_reg == CMS_WRITEBACK)
    begin
      line_valid     = 1'b1;
      line_writeback = 1'b1;
    end
    else if (state_reg == CMS_INVALIDATE)
    begin
      line_valid      = 1'b1;
      line_invalidate = 1'b1;
    end
  end

  always_comb
  begin
    sbc_code = CMS_SBC_NONE;
    if (state_reg == CMS_SYNC)
      sbc_code = CMS_SBC_SYNC;
    else if (state_reg == CMS_FLUSH)
      sbc_code = CMS_SBC_FLUSH;
  end

  // Geometry and descriptors are constants held in flip-flops after reset. Readers
  // see zero during reset and the fixed values from the first edge after it.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      id_result <= '0;
    else
      id_result <= {CMS_DESC_DTLB_SMALL, CMS_DESC_ITLB_LARGE,
                    CMS_DESC_ITLB_SMALL, CMS_DESC_BYTE0};
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      itlb_small_entries <= '0;
      itlb_small_ways    <= '0;
    end
    else
    begin
      itlb_small_entries <= 7'(CMS_ITLB_SMALL_ENTRIES);
      itlb_small_ways    <= 3'(CMS_ITLB_SMALL_WAYS);
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      itlb_large_entries    <= '0;
      itlb_large_full_assoc <= 1'b0;
    end
    else
    begin
      itlb_large_entries    <= 2'(CMS_ITLB_LARGE_ENTRIES);
      itlb_large_full_assoc <= (CMS_ITLB_LARGE_WAYS == CMS_ITLB_LARGE_ENTRIES);
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      dtlb_small_entries <= '0;
      dtlb_small_ways    <= '0;
    end
    else
    begin
      dtlb_small_entries <= 7'(CMS_DTLB_SMALL_ENTRIES);
      dtlb_small_ways    <= 3'(CMS_DTLB_SMALL_WAYS);
    end
  end

  // Refusal and acceptance each answer one cycle after the request and are never both high.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      remap_refused <= 1'b0;
    else
      remap_refused <= remap_valid && remap_forbidden(remap_from, remap_to);
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      remap_ok <= 1'b0;
    else
      remap_ok <= remap_valid && !remap_forbidden(remap_from, remap_to);
  end

endmodule : cms_sequencer

// >>> sim/cms_sequencer_asserts.sv
// Port checker for the maintenance sequencer.
// Assumes one clock, ref_clk, and a synchronous active-high rst.
`timescale 1ns/10ps
module cms_sequencer_asserts
  import cms_pkg::*;
(
  input wire logic ref_clk, rst, cmd_valid, cmd_ready, cmd_done, mem_hold, line_valid, line_ready,
  input wire logic line_level, line_writeback, line_invalidate, sbc_valid, sbc_ready,
  input wire logic itlb_large_full_assoc, remap_valid, remap_ok, remap_refused,
  input wire cms_cmd_t cmd_op,
  input wire cms_sbc_t sbc_code,
  input wire logic [CMS_IDX_W-1:0] line_index,
  input wire logic [CMS_WAY_W-1:0] line_way,
  input wire logic [31:0] id_result,
  input wire logic [6:0] itlb_small_entries, dtlb_small_entries,
  input wire logic [2:0] itlb_small_ways, dtlb_small_ways, remap_from, remap_to,
  input wire logic [1:0] itlb_large_entries
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence start_taken;
    cmd_valid && cmd_ready && cmd_op != CMS_CMD_NONE;
  endsequence
  sequence flush_taken;
    sbc_valid && sbc_ready && sbc_code == CMS_SBC_FLUSH;
  endsequence
  start_hold_a: assert property (start_taken |=> mem_hold && !cmd_ready)
    else $error("memory hold missing after start");
  flush_done_a: assert property (flush_taken |=> cmd_done && !mem_hold ##1 !cmd_done && cmd_ready)
    else $error("completion not one cycle after flush");
  done_cause_a: assert property (cmd_done |-> $past(sbc_valid && sbc_ready && sbc_code == CMS_SBC_FLUSH))
    else $error("completion without flush");
  bus_stable_a: assert property (sbc_valid && !sbc_ready |=> sbc_valid && $stable(sbc_code))
    else $error("bus cycle dropped before accept");
  bus_alone_a: assert property (sbc_valid |-> !line_valid && mem_hold)
    else $error("bus cycle overlaps line work");
  line_stable_a: assert property (line_valid && !line_ready |=> line_valid
    && $stable({line_level, line_index, line_way, line_writeback, line_invalidate}))
    else $error("line request changed before accept");
  remap_refuse_a: assert property (remap_valid && remap_from == CMS_MT_WRITE_BACK_TYPE
    && remap_to == CMS_MT_WRITE_THROUGH_TYPE |=> remap_refused && !remap_ok)
    else $error("write back to write through not refused");
  remap_pass_a: assert property (remap_valid && !(remap_from == CMS_MT_WRITE_BACK_TYPE
    && remap_to == CMS_MT_WRITE_THROUGH_TYPE) |=> remap_ok && !remap_refused)
    else $error("legal remap refused");
  geometry_a: assert property (!$past(rst) |-> id_result[31:8] == 24'h030201 && itlb_small_entries == 7'h20
    && itlb_small_ways == 3'h4 && itlb_large_entries == 2'h2 && itlb_large_full_assoc
    && dtlb_small_entries == 7'h40 && dtlb_small_ways == 3'h4)
    else $error("buffer geometry wrong");
endmodule : cms_sequencer_asserts

bind cms_sequencer cms_sequencer_asserts i_cms_sequencer_asserts (.ref_clk, .rst, .cmd_valid, .cmd_ready,
  .cmd_done, .mem_hold, .line_valid, .line_ready, .line_level, .line_writeback, .line_invalidate, .sbc_valid,
  .sbc_ready, .itlb_large_full_assoc, .remap_valid, .remap_ok, .remap_refused, .cmd_op, .sbc_code, .line_index,
  .line_way, .id_result, .itlb_small_entries, .dtlb_small_entries, .itlb_small_ways, .dtlb_small_ways,
  .remap_from, .remap_to, .itlb_large_entries);

// >>> sim/cms_partner.sv
// Cache arrays and system bus with an external cache controller.
// Assumes requests are held until ready; it stalls one line cycle in four.
`timescale 1ns/10ps
module cms_partner
  import cms_pkg::*;
(
  input wire logic ref_clk, rst, line_valid, line_writeback, line_invalidate, sbc_valid,
  input wire logic [CMS_IDX_W-1:0] line_index,
  input wire logic [CMS_WAY_W-1:0] line_way,
  input wire cms_sbc_t sbc_code,
  output logic line_ready, line_dirty, sbc_ready,
  output int n_probe, n_wb, n_inv, n_sbc, n_err,
  output cms_sbc_t sbc_prev, sbc_last
);
  logic [2:0] cyc_reg;
  logic due_reg;
  logic pick;
  logic probe;
  assign pick = line_index[1:0] == 2'h0 && line_way == 2'h1;
  assign probe = line_valid && !line_writeback && !line_invalidate;
  assign line_ready = cyc_reg[1:0] != 2'h0;
  assign sbc_ready = cyc_reg == 3'h7;
  // Outside a probe the status line toggles, so a stale sample is caught.
  assign line_dirty = probe ? pick : cyc_reg[0];
  always_ff @(posedge ref_clk)
  begin
    cyc_reg <= rst ? 3'h0 : cyc_reg + 3'h1;
    if (rst)
    begin
      {n_probe, n_wb, n_inv, n_sbc, n_err} <= '0;
      due_reg <= 1'b0;
    end
    else if (line_valid && line_ready)
    begin
      n_probe <= n_probe + int'(probe);
      n_wb <= n_wb + int'(line_writeback);
      n_inv <= n_inv + int'(line_invalidate);
      due_reg <= probe ? pick : due_reg && !line_writeback;
      if ((line_writeback && !due_reg) || (line_invalidate && due_reg))
        n_err <= n_err + 1;
    end
    else if (sbc_valid && sbc_ready)
    begin
      n_sbc <= n_sbc + 1;
      sbc_prev <= sbc_last;
      sbc_last <= sbc_code;
    end
  end
endmodule : cms_partner

// >>> sim/cms_sequencer_tb.sv
// Self-checking bench for the maintenance sequencer with its partner model.
// Assumes the checker is attached by bind; inputs change on the falling edge.
`timescale 1ns/10ps
module cms_sequencer_tb
  import cms_pkg::*;
;
  localparam int LINES = CMS_WAYS * (CMS_L1_SETS + CMS_L2_SETS);
  logic ref_clk = 1'b0, rst = 1'b1, cmd_valid = 1'b0, remap_valid = 1'b0;
  logic [2:0] remap_from = 3'h0, remap_to = 3'h0;
  cms_cmd_t cmd_op = CMS_CMD_NONE;
  logic cmd_ready, cmd_done, mem_hold, line_valid, line_ready, line_level, line_writeback, line_invalidate;
  logic line_dirty, sbc_valid, sbc_ready, itlb_large_full_assoc, remap_ok, remap_refused;
  logic [CMS_IDX_W-1:0] line_index;
  logic [CMS_WAY_W-1:0] line_way;
  cms_sbc_t sbc_code, sbc_prev, sbc_last;
  logic [31:0] id_result;
  logic [6:0] itlb_small_entries, dtlb_small_entries;
  logic [2:0] itlb_small_ways, dtlb_small_ways;
  logic [1:0] itlb_large_entries;
  int n_probe, n_wb, n_inv, n_sbc, n_err, miscompares = 0, cmp_count = 0;
  // Row: from, to, ok, refused.
  logic [7:0] rows [6] = '{8'hC2, 8'hD1, 8'hDA, 8'h9A, 8'h22, 8'hA6};
  always #4 ref_clk = ~ref_clk;
  cms_sequencer i_cms_sequencer (.ref_clk, .rst, .cmd_valid, .cmd_ready, .cmd_op, .cmd_done, .mem_hold,
    .line_valid, .line_ready, .line_level, .line_index, .line_way, .line_writeback, .line_invalidate,
    .line_dirty, .sbc_valid, .sbc_ready, .sbc_code, .id_result, .itlb_small_entries, .itlb_small_ways,
    .itlb_large_entries, .itlb_large_full_assoc, .dtlb_small_entries, .dtlb_small_ways, .remap_valid,
    .remap_from, .remap_to, .remap_ok, .remap_refused);
  cms_partner i_cms_partner (.ref_clk, .rst, .line_valid, .line_writeback, .line_invalidate, .sbc_valid,
    .line_index, .line_way, .sbc_code, .line_ready, .line_dirty, .sbc_ready, .n_probe, .n_wb, .n_inv,
    .n_sbc, .n_err, .sbc_prev, .sbc_last);
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    cmp_count++;
    if (seen !== want)
    begin
      miscompares++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, want);
    end
  endtask : check
  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : summarize
  task automatic run_cmd(input cms_cmd_t op, input int probes, input int wbs, input int sbcs);
    int p0, w0, i0, s0, n;
    {p0, w0, i0, s0, n} = {n_probe, n_wb, n_inv, n_sbc, 32'h0};
    cmd_valid = 1'b1;
    cmd_op = op;
    @(negedge ref_clk);
    cmd_valid = 1'b0;
    check(mem_hold, 1'b1);
    while (cmd_done !== 1'b1 && n < 30000)
    begin
      @(negedge ref_clk);
      n++;
    end
    if (n == 30000)
    begin
      miscompares++;
      summarize();
    end
    check({mem_hold, sbc_last}, {1'b0, CMS_SBC_FLUSH});
    check(n_inv - i0, LINES);
    check(n_probe - p0, probes);
    check(n_wb - w0, wbs);
    check(n_sbc - s0, sbcs);
    @(negedge ref_clk);
    $display("command %0h test ended", op);
  endtask : run_cmd
  initial
  begin
    repeat (20) @(negedge ref_clk);
    check({cmd_ready, cmd_done, mem_hold, sbc_valid, line_valid}, 5'h10);
    rst = 1'b0;
    repeat (2) @(negedge ref_clk);
    check(id_result[31:8], 24'h030201);
    check({itlb_small_entries, itlb_small_ways}, {7'h20, 3'h4});
    check({itlb_large_entries, itlb_large_full_assoc}, 3'h5);
    check({dtlb_small_entries, dtlb_small_ways}, {7'h40, 3'h4});
    $display("reset test ended");
    foreach (rows[i])
    begin
      {remap_valid, remap_from, remap_to} = {1'b1, rows[i][7:5], rows[i][4:2]};
      @(negedge ref_clk);
      check({remap_ok, remap_refused}, rows[i][1:0]);
    end
    remap_valid = 1'b0;
    $display("remap test ended");
    cmd_valid = 1'b1;
    repeat (2) @(negedge ref_clk);
    check({cmd_ready, mem_hold}, 2'h2);
    cmd_valid = 1'b0;
    run_cmd(CMS_CMD_INVALIDATE_WITHOUT_WRITEBACK, 0, 0, 1);
    run_cmd(CMS_CMD_WRITEBACK_THEN_INVALIDATE, LINES, LINES / 16, 2);
    check(sbc_prev, CMS_SBC_SYNC);
    check(n_err, 0);
    summarize();
  end
endmodule : cms_sequencer_tb
